// ---- core/isf_pkg.sv ----
package isf_pkg;
  localparam int          AddrWidth     = 4;
  localparam int          DataWidth     = 32;
  localparam int          StatusWidth   = 16;
  localparam logic [3:0]  OffStatus     = 4'h0;
  localparam logic [3:0]  OffMask       = 4'h4;
  localparam logic [3:0]  OffEvent      = 4'h8;
  localparam logic [3:0]  OffControl    = 4'hC;
  localparam int          BitAckMissing = 15;
  localparam int          BitTxActive   = 14;
  localparam int          BitCollision  = 10;
  localparam int          BitGenCall    = 9;
  localparam int          BitTenBit     = 8;
  localparam int          BitWriteCol   = 7;
  localparam int          BitOverflow   = 6;
  localparam int          BitDataAddr   = 5;
  localparam int          BitStop       = 4;
  localparam int          BitStart      = 3;
  localparam int          BitReadWrite  = 2;
  localparam int          BitRxFull     = 1;
  localparam int          BitTxFull     = 0;
  localparam int          EvtCount      = 4;
  localparam int          EvtCollision  = 0;
  localparam int          EvtWriteCol   = 1;
  localparam int          EvtOverflow   = 2;
  localparam int          EvtAckMissing = 3;
  localparam int          CtlEnable     = 0;
  localparam logic [15:0] StatusMask    = 16'hC7FF;
  localparam logic [15:0] StatusReset   = 16'h0000;
  localparam logic [3:0]  EvtReset      = 4'h0;
endpackage : isf_pkg

// ---- core/isf_bus_if.sv ----
interface isf_bus_if;
  logic [isf_pkg::StatusWidth-1:0] status;
  logic [isf_pkg::EvtCount-1:0]    events;
  logic [isf_pkg::EvtCount-1:0]    mask;
  logic [isf_pkg::EvtCount-1:0]    clearOnes;
  logic                            clearWrite;
  logic                            irq;
  modport core (output status, output events);
  modport irqs (input events, input mask, input clearOnes, input clearWrite, output irq);
  modport top (input status, input irq, output mask, output clearOnes, output clearWrite);
endinterface : isf_bus_if

// ---- core/isf_irq.sv ----
module isf_irq
  import isf_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  isf_bus_if.irqs   bus
);
  typedef struct packed {
    logic [EvtCount-1:0] sticky;
    logic                irq;
  } isf_irq_s;

  isf_irq_s stateReg;
  isf_irq_s stateNext;

  always_comb
  begin
    stateNext = stateReg;
    // Set wins over a write-one clear in the same cycle.
    if (bus.clearWrite)
    begin
      stateNext.sticky = stateReg.sticky & ~bus.clearOnes;
    end
    stateNext.sticky = stateNext.sticky | bus.events;
    stateNext.irq    = |(stateNext.sticky & bus.mask);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateReg <= '0;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign bus.irq = stateReg.irq;
endmodule : isf_irq

// ---- core/isf_status.sv ----
// Functional notes
// RULE_01: Master transmit: ack-missing flag takes slave ack result when ack ends.
// RULE_02: Master-transmit-active set at transmission start, cleared when slave ack ends.
// RULE_03: Bus-collision flag set on collision during any master operation.
// RULE_04: Collision flag ignores software; clears only on disable then re-enable.
// RULE_05: General-call flag set on general call match, cleared at stop.
// RULE_06: Ten-bit match flag set on second address byte match, cleared at stop.
// RULE_07: Transmit holding write while busy fails, sets sticky write-collision flag.
// RULE_08: Receive transfer while holding register full sets overflow flag; software clears.
// RULE_09: Slave: data-or-address flag cleared on address match, set on data byte.
// RULE_10: Bits 31..16 and 13..11 read zero and ignore writes.
// RULE_11: Bits 4..0 hold stop, start, direction, rx full, tx full; reset zero.
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
module isf_status
  import isf_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset_n,
  input  wire logic [AddrWidth-1:0]  regAddr,
  input  wire logic [DataWidth-1:0]  regWdata,
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  output logic      [DataWidth-1:0]  regRdata,
  input  wire logic                  busBusy,
  input  wire logic                  masterTxStart,
  input  wire logic                  slaveAckEnd,
  input  wire logic                  slaveAckLow,
  input  wire logic                  collisionSeen,
  input  wire logic                  genCallMatch,
  input  wire logic                  tenBitMatch,
  input  wire logic                  addrMatch,
  input  wire logic                  slaveAddrRead,
  input  wire logic                  dataByteRcvd,
  input  wire logic                  rxTransfer,
  input  wire logic                  rxHoldingRead,
  input  wire logic                  txHoldingWrite,
  input  wire logic                  txShiftLoad,
  input  wire logic                  startDetected,
  input  wire logic                  stopDetected,
  output logic                       txWriteAccept,
  output logic                       rxLoad,
  output logic                       moduleEnable,
  output logic                       irqOut
);
  typedef struct packed {
    logic [StatusWidth-1:0] status;
    logic [EvtCount-1:0]    mask;
    logic                   enable;
    logic [DataWidth-1:0]   rdata;
    logic                   txAccept;
    logic                   rxLoad;
    logic [EvtCount-1:0]    eventView;
  } isf_state_s;

  isf_state_s stateReg;
  isf_state_s stateNext;
  isf_bus_if  irqBus ();

  function automatic logic isWrite(input logic [AddrWidth-1:0] a,
                                   input logic [AddrWidth-1:0] off,
                                   input logic                 w);
    isWrite = w && (a == off);
  endfunction : isWrite

  logic writeStatus;
  logic writeMask;
  logic writeEvent;
  logic writeControl;
  logic reEnable;
  logic rxFullNow;
  logic txFullNow;
  logic [EvtCount-1:0] events;

  always_comb
  begin
    writeStatus  = isWrite(regAddr, OffStatus, regWrite);
    writeMask    = isWrite(regAddr, OffMask, regWrite);
    writeEvent   = isWrite(regAddr, OffEvent, regWrite);
    writeControl = isWrite(regAddr, OffControl, regWrite);
    reEnable     = writeControl && regWdata[CtlEnable] && !stateReg.enable;
    rxFullNow    = stateReg.status[BitRxFull];
    txFullNow    = stateReg.status[BitTxFull];
    events       = '0;
    stateNext    = stateReg;
    stateNext.txAccept = 1'b0;
    stateNext.rxLoad   = 1'b0;
    if (writeMask)
    begin
      stateNext.mask = regWdata[EvtCount-1:0];
    end
    if (writeControl)
    begin
      stateNext.enable = regWdata[CtlEnable];
    end
    if (stateReg.enable)
    begin
      // RULE_02 transmit active
      if (masterTxStart)
      begin
        stateNext.status[BitTxActive] = 1'b1;
      end
      else if (slaveAckEnd)
      begin
        stateNext.status[BitTxActive] = 1'b0;
      end
      // RULE_01 ack result latch
      if (slaveAckEnd && stateReg.status[BitTxActive])
      begin
        stateNext.status[BitAckMissing] = !slaveAckLow;
        events[EvtAckMissing] = !slaveAckLow;
      end
      // RULE_03 collision detect
      if (collisionSeen)
      begin
        stateNext.status[BitCollision] = 1'b1;
        events[EvtCollision] = 1'b1;
      end
      // RULE_05 general call
      // RULE_06 ten bit match
      if (stopDetected)
      begin
        stateNext.status[BitGenCall] = 1'b0;
        stateNext.status[BitTenBit]  = 1'b0;
      end
      if (genCallMatch)
      begin
        stateNext.status[BitGenCall] = 1'b1;
      end
      if (tenBitMatch)
      begin
        stateNext.status[BitTenBit] = 1'b1;
      end
      // RULE_09 last byte kind
      if (addrMatch)
      begin
        stateNext.status[BitDataAddr]  = 1'b0;
        stateNext.status[BitReadWrite] = slaveAddrRead;
      end
      else if (dataByteRcvd)
      begin
        stateNext.status[BitDataAddr] = 1'b1;
      end
      // RULE_11 start and stop seen
      if (startDetected)
      begin
        stateNext.status[BitStart] = 1'b1;
        stateNext.status[BitStop]  = 1'b0;
      end
      else if (stopDetected)
      begin
        stateNext.status[BitStop]  = 1'b1;
        stateNext.status[BitStart] = 1'b0;
      end
    end
    // RULE_04 collision sticky
    if (reEnable)
    begin
      stateNext.status[BitCollision] = 1'b0;
    end
    // RULE_07 write collision
    // RULE_08 receive overflow
    // Software clears these by writing one; a same-cycle event still sets them.
    if (writeStatus)
    begin
      if (regWdata[BitWriteCol])
      begin
        stateNext.status[BitWriteCol] = 1'b0;
      end
      if (regWdata[BitOverflow])
      begin
        stateNext.status[BitOverflow] = 1'b0;
      end
    end
    // RULE_11 holding flags
    if (txShiftLoad)
    begin
      stateNext.status[BitTxFull] = 1'b0;
    end
    if (rxHoldingRead)
    begin
      stateNext.status[BitRxFull] = 1'b0;
    end
    if (txHoldingWrite)
    begin
      // RULE_07 busy write fails
      if (busBusy || txFullNow)
      begin
        stateNext.status[BitWriteCol] = 1'b1;
        events[EvtWriteCol] = 1'b1;
      end
      else
      begin
        stateNext.txAccept = 1'b1;
        stateNext.status[BitTxFull] = 1'b1;
      end
    end
    if (rxTransfer)
    begin
      // RULE_08 overflow keeps old byte
      if (rxFullNow && !rxHoldingRead)
      begin
        stateNext.status[BitOverflow] = 1'b1;
        events[EvtOverflow] = 1'b1;
      end
      else
      begin
        stateNext.rxLoad = 1'b1;
        stateNext.status[BitRxFull] = 1'b1;
      end
    end
    // Readback copy of the irq sticky bits; it must clear exactly as the irq block does.
    stateNext.eventView = stateReg.eventView | events;
    if (writeEvent)
    begin
      stateNext.eventView = (stateReg.eventView & ~regWdata[EvtCount-1:0]) | events;
    end
    // RULE_10 unimplemented bits zero
    stateNext.status = stateNext.status & StatusMask;
    stateNext.rdata  = '0;
    if (regRead)
    begin
      case (regAddr)
        OffStatus:  stateNext.rdata = {16'h0000, stateReg.status & StatusMask};
        OffMask:    stateNext.rdata = {28'h0000000, stateReg.mask};
        OffEvent:   stateNext.rdata = {28'h0000000, irqBus.status[EvtCount-1:0]};
        OffControl: stateNext.rdata = {31'h00000000, stateReg.enable};
        default:    stateNext.rdata = '0;
      endcase
    end
  end

  // The irq block keeps its own sticky copy so that status bits stay pure hardware state.
  assign irqBus.mask       = stateReg.mask;
  assign irqBus.clearOnes  = regWdata[EvtCount-1:0];
  assign irqBus.clearWrite = writeEvent;
  assign irqBus.events     = events;

  isf_irq u_irq
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .bus     (irqBus.irqs)
  );

  assign irqBus.status = {12'h000, stateReg.eventView};

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stateReg <= '0;
    end
    else
    begin
      stateReg <= stateNext;
    end
  end

  assign regRdata      = stateReg.rdata;
  assign txWriteAccept = stateReg.txAccept;
  assign rxLoad        = stateReg.rxLoad;
  assign moduleEnable  = stateReg.enable;
  assign irqOut        = irqBus.irq;
endmodule : isf_status

// ---- dv/isf_status_props.sv ----
module isf_status_props
  import isf_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic [AddrWidth-1:0] regAddr,
  input wire logic [DataWidth-1:0] regWdata,
  input wire logic                 regWrite,
  input wire logic                 regRead,
  input wire logic [DataWidth-1:0] regRdata,
  input wire logic                 busBusy,
  input wire logic                 txHoldingWrite,
  input wire logic                 txWriteAccept,
  input wire logic                 rxTransfer,
  input wire logic                 rxLoad,
  input wire logic                 collisionSeen,
  input wire logic                 moduleEnable,
  input wire logic                 irqOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic maskBit_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      maskBit_reg <= 1'b0;
    else if (regWrite && regAddr == OffMask)
      maskBit_reg <= regWdata[EvtCollision];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_unmapped_zero: assert property (
    regRead && regAddr[1:0] != 2'h0 |=> regRdata == '0) else $error("Unmapped read not zero");
  a_status_upper_zero: assert property (
    regRead && regAddr == OffStatus |=> regRdata[31:16] == 16'h0000 && regRdata[13:11] == 3'h0)
    else $error("Unimplemented status bits set");
  a_busy_write_refused: assert property (
    txHoldingWrite && busBusy |=> !txWriteAccept) else $error("Busy write accepted");
  a_accept_has_cause: assert property (
    txWriteAccept |-> $past(txHoldingWrite) && !$past(busBusy)) else $error("Stray accept");
  a_load_has_cause: assert property (
    rxLoad |-> $past(rxTransfer) ##1 !rxLoad) else $error("Stray receive load");
  a_enable_follows: assert property (
    regWrite && regAddr == OffControl |=> moduleEnable == $past(regWdata[CtlEnable]))
    else $error("Enable not written");
  a_enable_holds: assert property (
    !(regWrite && regAddr == OffControl) |=> $stable(moduleEnable)) else $error("Enable moved");
  a_collision_irq: assert property (
    collisionSeen && moduleEnable && maskBit_reg && !regWrite |-> ##2 irqOut)
    else $error("Collision raised no interrupt");
endmodule : isf_status_props

bind isf_status isf_status_props u_isf_status_props (.sys_clk, .reset_n, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .busBusy, .txHoldingWrite, .txWriteAccept, .rxTransfer,
  .rxLoad, .collisionSeen, .moduleEnable, .irqOut);

// ---- dv/isf_bus_partner.sv ----
module isf_bus_partner (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] evtCode,
  input  wire logic       evtGo,
  input  wire logic       ackGiven,
  output logic      [9:0] pulses,
  output logic            ackLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus events reach the block as single-cycle pulses, one edge after the request.
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      pulses   <= 10'h000;
      ackLevel <= 1'b0;
    end
    else
    begin
      pulses   <= evtGo ? (10'h001 << evtCode) : 10'h000;
      ackLevel <= ackGiven;
    end
endmodule : isf_bus_partner

// ---- dv/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import isf_pkg::*;
  localparam logic [31:0] ChkMask = 32'hFFFFFFE0;
  logic                 sys_clk, reset_n, regWrite, regRead, busBusy, rxHoldingRead, evtGo;
  logic                 txHoldingWrite, txShiftLoad, ackGiven, ackLevel, rdSeen;
  logic                 txWriteAccept, rxLoad, moduleEnable, irqOut;
  logic [3:0]           evtCode;
  logic [9:0]           pulses;
  logic [AddrWidth-1:0] regAddr;
  logic [DataWidth-1:0] regWdata, regRdata;
  logic [15:0]          rnd;
  logic [63:0]          expQ[$];
  int                   errorCnt, samplesChecked;
  int                   cycles = 0;

  isf_bus_partner u_isf_bus_partner (.sys_clk, .reset_n, .evtCode, .evtGo, .ackGiven, .pulses,
    .ackLevel);
  isf_status u_isf_status (.sys_clk, .reset_n, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .busBusy, .masterTxStart(pulses[0]), .slaveAckEnd(pulses[1]),
    .slaveAckLow(ackLevel), .collisionSeen(pulses[2]), .genCallMatch(pulses[3]),
    .tenBitMatch(pulses[4]), .addrMatch(pulses[5]), .slaveAddrRead(ackLevel),
    .dataByteRcvd(pulses[6]), .rxTransfer(pulses[9]), .rxHoldingRead, .txHoldingWrite,
    .txShiftLoad, .startDetected(pulses[7]), .stopDetected(pulses[8]), .txWriteAccept, .rxLoad,
    .moduleEnable, .irqOut);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  task automatic giveVerdict();
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : giveVerdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // A gap cycle after each strobe keeps one assignment per signal per time step.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    regWrite <= w;
    regRead  <= !w;
    regAddr  <= a;
    regWdata <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back({m, e});
    bus(1'b0, a, 32'h00000000);
  endtask : rd

  task automatic evt(input logic [3:0] c);
    evtCode <= c;
    evtGo   <= 1'b1;
    @(posedge sys_clk);
    evtGo <= 1'b0;
    @(posedge sys_clk);
  endtask : evt

  task automatic irqChk(input logic e);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("irqOut", {31'h0, e}, {31'h0, irqOut});
    @(posedge sys_clk);
  endtask : irqChk

  always @(posedge sys_clk)
  begin
    rdSeen <= regRead;
    cycles <= cycles + 1;
    if (rdSeen === 1'b1 && expQ.size() > 0)
    begin
      chk("regRdata", expQ[0][31:0], regRdata & expQ[0][63:32]);
      void'(expQ.pop_front());
    end
    if (cycles == 3000)
    begin
      errorCnt++;
      giveVerdict();
    end
  end

  initial
  begin
    {regWrite, regRead, busBusy, rxHoldingRead, txHoldingWrite, txShiftLoad} = 6'h00;
    {evtGo, ackGiven, reset_n} = 3'h0;
    {evtCode, regAddr, regWdata} = 40'h0000000000;
    errorCnt = 0;
    samplesChecked = 0;
    rnd = 16'h0051;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(OffStatus, 32'h00000000, 32'hFFFFFFFF);
    rd(4'h2, 32'h00000000, 32'hFFFFFFFF);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      bus(1'b1, OffStatus, {rnd, ~rnd});
      rd(OffStatus, 32'h00000000, ChkMask);
    end
    bus(1'b1, OffControl, 32'h00000001);
    bus(1'b1, OffMask, 32'h00000001);
    evt(4'h0);
    rd(OffStatus, 32'h00004000, ChkMask);
    evt(4'h1);
    rd(OffStatus, 32'h00008000, ChkMask);
    ackGiven <= 1'b1;
    evt(4'h0);
    evt(4'h1);
    rd(OffStatus, 32'h00000000, ChkMask);
    evt(4'h2);
    irqChk(1'b1);
    bus(1'b1, OffStatus, 32'hFFFFFFFF);
    rd(OffStatus, 32'h00000400, ChkMask);
    bus(1'b1, OffEvent, 32'h00000001);
    irqChk(1'b0);
    rd(OffEvent, 32'h00000008, 32'hFFFFFFFF);
    bus(1'b1, OffControl, 32'h00000000);
    chk("moduleEnable", 32'h0, {31'h0, moduleEnable});
    bus(1'b1, OffControl, 32'h00000001);
    rd(OffStatus, 32'h00000000, ChkMask);
    rd(OffControl, 32'h00000001, 32'hFFFFFFFF);
    evt(4'h3);
    evt(4'h4);
    rd(OffStatus, 32'h00000300, ChkMask);
    evt(4'h8);
    rd(OffStatus, 32'h00000000, ChkMask);
    busBusy        <= 1'b1;
    txHoldingWrite <= 1'b1;
    @(posedge sys_clk);
    {busBusy, txHoldingWrite} <= 2'h0;
    @(posedge sys_clk);
    rd(OffStatus, 32'h00000080, ChkMask);
    bus(1'b1, OffStatus, 32'h00000080);
    rd(OffStatus, 32'h00000000, ChkMask);
    txHoldingWrite <= 1'b1;
    @(posedge sys_clk);
    txHoldingWrite <= 1'b0;
    txShiftLoad    <= 1'b1;
    #1 chk("txWriteAccept", 32'h1, {31'h0, txWriteAccept});
    @(posedge sys_clk);
    txShiftLoad <= 1'b0;
    evt(4'h9);
    #1 chk("rxLoad", 32'h1, {31'h0, rxLoad});
    @(posedge sys_clk);
    evt(4'h9);
    #1 chk("rxLoad", 32'h0, {31'h0, rxLoad});
    @(posedge sys_clk);
    rd(OffStatus, 32'h00000040, ChkMask);
    bus(1'b1, OffStatus, 32'h00000040);
    rd(OffStatus, 32'h00000000, ChkMask);
    ackGiven <= 1'b0;
    evt(4'h5);
    evt(4'h6);
    rd(OffStatus, 32'h00000020, ChkMask);
    evt(4'h5);
    rd(OffStatus, 32'h00000000, ChkMask);
    bus(1'b1, OffMask, 32'h00000000);
    evt(4'h2);
    irqChk(1'b0);
    bus(1'b1, OffMask, 32'h00000001);
    irqChk(1'b1);
    bus(1'b1, OffEvent, 32'h00000001);
    irqChk(1'b0);
    rd(OffEvent, 32'h0000000E, 32'hFFFFFFFF);
    evt(4'h7);
    rd(OffStatus, 32'h0000000A, 32'h0000001F);
    rxHoldingRead <= 1'b1;
    @(posedge sys_clk);
    rxHoldingRead <= 1'b0;
    @(posedge sys_clk);
    rd(OffStatus, 32'h00000008, 32'h0000001F);
    repeat (2) @(posedge sys_clk);
    giveVerdict();
  end
endmodule : testbench
